// ==== gpx_pkg.sv ====
// Constants, register map and carrier types for the port pin access and pull-up block.
package gpx_pkg;
	// Port slots 0..5 are the bidirectional ports 0, 3, 4, 5, 8 and 9.
	localparam int NPORT = 6;
	localparam int P4_SLOT = 2;
	localparam logic [2:0] P2_SEL = 3'h6;
	localparam logic [NPORT*8-1:0] PORT_MASKS = {8'h07, 8'h3F, 8'hFF, 8'hFF, 8'h1F, 8'hFF};
	// Register byte offsets.
	localparam logic [11:0] OFS_PORT_BASE = 12'h000;
	localparam logic [11:0] OFS_P2_DATA = 12'h060;
	localparam logic [11:0] OFS_READ_CTRL = 12'h070;
	localparam logic [11:0] OFS_PU_LOW = 12'h074;
	localparam logic [11:0] OFS_PU_HIGH = 12'h078;
	localparam logic [11:0] OFS_CMP = 12'h07C;
	localparam logic [3:0] OFS_LATCH = 4'h0;
	localparam logic [3:0] OFS_DIR = 4'h4;
	localparam logic [3:0] OFS_MODE = 4'h8;
	// Implemented bit masks and the NMI pin mask.
	localparam logic [7:0] READ_CTRL_IMPL = 8'h01;
	localparam logic [7:0] PU_LOW_IMPL = 8'h3F;
	localparam logic [7:0] PU_HIGH_IMPL = 8'h03;
	localparam logic [7:0] NMI_PIN_MASK = 8'h01;
	// Pull-up bit positions.
	localparam int PU_P0 = 0;
	localparam int PU_P2 = 2;
	localparam int PU_P3 = 3;
	localparam int PU_P4 = 4;
	localparam int PU_P5 = 5;
	localparam int PU_P8 = 0;
	localparam int PU_P9 = 1;
	// Compare register fields.
	localparam int CMP_RES_LSB = 8;
	localparam int CMP_DONE_BIT = 16;
	localparam int CMP_BUSY_BIT = 17;
	// Reset values.
	localparam logic [7:0] RST_DIR = 8'hFF;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe;
		logic [7:0] pu;
	} gpx_pad_t;

	typedef enum logic [1:0] {
		CMP_IDLE = 2'b01,
		CMP_END = 2'b10
	} gpx_cmp_state_t;
endpackage : gpx_pkg

// ==== gpx_port_slice.sv ====
// One bidirectional port: output latch, direction, port/control mode, pad drive and read value.
`timescale 1ns/10ps
module gpx_port_slice
	import gpx_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hFF
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Register writes
	input wire logic we_latch,
	input wire logic we_dir,
	input wire logic we_mode,
	input wire logic [7:0] wdata,
	// Control
	input wire logic pin_read_mode,
	input wire logic pu_sel,
	// Pins and control function outputs
	input wire logic [7:0] pin_in,
	input wire logic [7:0] ctrl_out,
	// Results
	output gpx_pad_t pad,
	output logic [7:0] latch,
	output logic [7:0] dir,
	output logic [7:0] mode,
	output logic [7:0] rd_data
);
	logic [7:0] latch_r;
	logic [7:0] dir_r;
	logic [7:0] mode_r;
	wire logic [7:0] in_pins = dir_r & MASK;
	wire logic [7:0] out_pins = ~dir_r & MASK;
	wire logic [7:0] normal_rd = (latch_r & out_pins) | (pin_in & in_pins);
	wire logic [7:0] pin_rd = pin_in & out_pins;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_r <= RST_LATCH;
			dir_r <= RST_DIR;
			mode_r <= RST_MODE;
		end else if (ce) begin
			if (we_latch) latch_r <= wdata & MASK;
			if (we_dir) dir_r <= wdata & MASK;
			if (we_mode) mode_r <= wdata & MASK;
		end
	end

	assign pad.dout = (mode_r & ctrl_out) | (~mode_r & latch_r);
	assign pad.oe = out_pins;
	assign pad.pu = {8{pu_sel}} & in_pins;
	assign rd_data = pin_read_mode ? pin_rd : normal_rd;
	assign latch = latch_r;
	assign dir = dir_r;
	assign mode = mode_r;
endmodule : gpx_port_slice

// ==== gpx_top.sv ====
// Port pin access, latch-versus-pin compare and pull-up control behind an AXI4-Lite slave.
// How it works
// - Reset makes all port pins inputs.
// - Read control bits 7..1 read zero.
// - Pin read mode breaks bit operations.
// - Pin mode: outputs read pins, inputs zero.
// - Input pins compare as matching, except on ports 2 and 4.
// - Port 4 input change gives mismatch.
// - NMI pin never gets a pull-up.
// - Pull-up bit enables port pull-ups.
// - Pull-up unused high bits read zero.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module gpx_top
	import gpx_pkg::*;
(
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Bidirectional port pins and control functions
	input wire logic [NPORT-1:0][7:0] pin_in,
	input wire logic [NPORT-1:0][7:0] ctrl_out,
	output gpx_pad_t [NPORT-1:0] pad,
	// Dedicated input port 2
	input wire logic [7:0] port2_in,
	output logic [7:0] port2_pu
);
	function automatic logic port_hit(input logic [11:0] a, input int p, input logic [3:0] sub);
		port_hit = (a == (OFS_PORT_BASE + 12'(p * 16) + {8'h00, sub}));
	endfunction : port_hit

	function automatic logic reg_mapped(input logic [11:0] a);
		reg_mapped = (a < 12'(NPORT * 16) && a[3:0] <= OFS_MODE && a[1:0] == 2'h0) ||
			a == OFS_P2_DATA || a == OFS_READ_CTRL || a == OFS_PU_LOW ||
			a == OFS_PU_HIGH || a == OFS_CMP;
	endfunction : reg_mapped

	function automatic logic [7:0] sel_pins_at(input logic [2:0] s);
		sel_pins_at = 8'h00;
		for (int i = 0; i < NPORT; i++) begin
			if (s == 3'(i)) sel_pins_at = pin_in[i] & PORT_MASKS[i*8 +: 8];
		end
	endfunction : sel_pins_at

	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic [11:0] rd_addr_r;
	logic [7:0] read_ctrl_r;
	logic [7:0] pu_low_r;
	logic [7:0] pu_high_r;
	gpx_cmp_state_t cmp_state_r;
	gpx_cmp_state_t cmp_state_nxt;
	logic [2:0] cmp_sel_r;
	logic [7:0] cmp_snap_r;
	logic [7:0] cmp_res_r;
	logic [7:0] cmp_res_nxt;
	logic cmp_done_r;

	wire logic wr_go = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_r;
	wire logic rd_go = ce && s_axi_arvalid && !rvalid_r;
	wire logic wr_lane = s_axi_wstrb[0];
	wire logic [7:0] wbyte = s_axi_wdata[7:0];
	wire logic pin_read_mode_bit = read_ctrl_r[0];
	wire logic we_read_ctrl = wr_go && wr_lane && s_axi_awaddr == OFS_READ_CTRL;
	wire logic we_pu_low = wr_go && wr_lane && s_axi_awaddr == OFS_PU_LOW;
	wire logic we_pu_high = wr_go && wr_lane && s_axi_awaddr == OFS_PU_HIGH;
	wire logic we_cmp = wr_go && wr_lane && s_axi_awaddr == OFS_CMP && cmp_state_r == CMP_IDLE;

	wire logic [NPORT-1:0] pu_sel = {pu_high_r[PU_P9], pu_high_r[PU_P8], pu_low_r[PU_P5],
		pu_low_r[PU_P4], pu_low_r[PU_P3], pu_low_r[PU_P0]};
	logic [NPORT-1:0][7:0] latch_v;
	logic [NPORT-1:0][7:0] dir_v;
	logic [NPORT-1:0][7:0] mode_v;
	logic [NPORT-1:0][7:0] rd_v;
	logic [NPORT-1:0][7:0] port_rd_sel;

	genvar gi;
	generate
		for (gi = 0; gi < NPORT; gi++) begin : g_port
			gpx_port_slice #(
				.MASK(PORT_MASKS[gi*8 +: 8])
			) u_slice (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.we_latch(wr_go && wr_lane && port_hit(s_axi_awaddr, gi, OFS_LATCH)),
				.we_dir(wr_go && wr_lane && port_hit(s_axi_awaddr, gi, OFS_DIR)),
				.we_mode(wr_go && wr_lane && port_hit(s_axi_awaddr, gi, OFS_MODE)),
				.wdata(wbyte),
				.pin_read_mode(pin_read_mode_bit),
				.pu_sel(pu_sel[gi]),
				.pin_in(pin_in[gi]),
				.ctrl_out(ctrl_out[gi]),
				.pad(pad[gi]),
				.latch(latch_v[gi]),
				.dir(dir_v[gi]),
				.mode(mode_v[gi]),
				.rd_data(rd_v[gi])
			);
			assign port_rd_sel[gi] = port_hit(s_axi_araddr, gi, OFS_LATCH) ? rd_v[gi] :
				port_hit(s_axi_araddr, gi, OFS_DIR) ? dir_v[gi] :
				port_hit(s_axi_araddr, gi, OFS_MODE) ? mode_v[gi] : 8'h00;
		end
	endgenerate

	// No pull-up on the NMI pin.
	assign port2_pu = {8{pu_low_r[PU_P2]}} & ~NMI_PIN_MASK;

	logic [7:0] port_rd_any;
	always_comb begin
		port_rd_any = 8'h00;
		for (int i = 0; i < NPORT; i++) begin
			port_rd_any = port_rd_any | port_rd_sel[i];
		end
	end

	wire logic [31:0] cmp_word = {14'h0000, cmp_state_r == CMP_END, cmp_done_r, cmp_res_r, 5'h00, cmp_sel_r};
	wire logic [31:0] rd_word = (s_axi_araddr == OFS_P2_DATA) ? {24'h000000, port2_in} :
		(s_axi_araddr == OFS_READ_CTRL) ? {24'h000000, read_ctrl_r} :
		(s_axi_araddr == OFS_PU_LOW) ? {24'h000000, pu_low_r} :
		(s_axi_araddr == OFS_PU_HIGH) ? {24'h000000, pu_high_r} :
		(s_axi_araddr == OFS_CMP) ? cmp_word : {24'h000000, port_rd_any};

	// Write and read channels; both address and data are taken in the same cycle.
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = rd_go;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= reg_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h00000000;
			rd_addr_r <= 12'h000;
		end else if (ce) begin
			if (rd_go) begin
				rvalid_r <= 1'b1;
				rresp_r <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				rdata_r <= reg_mapped(s_axi_araddr) ? rd_word : 32'h00000000;
				rd_addr_r <= s_axi_araddr;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			read_ctrl_r <= RST_CTRL;
			pu_low_r <= RST_CTRL;
			pu_high_r <= RST_CTRL;
		end else if (ce) begin
			if (we_read_ctrl) read_ctrl_r <= wbyte & READ_CTRL_IMPL;
			if (we_pu_low) pu_low_r <= wbyte & PU_LOW_IMPL;
			if (we_pu_high) pu_high_r <= wbyte & PU_HIGH_IMPL;
		end
	end

	// Compare: first cycle snapshots the pins, second cycle judges latch against pin.
	logic [7:0] sel_pins;
	logic [7:0] sel_latch;
	logic [7:0] sel_dir;
	always_comb begin
		sel_pins = 8'h00;
		sel_latch = 8'h00;
		sel_dir = 8'h00;
		for (int i = 0; i < NPORT; i++) begin
			if (cmp_sel_r == 3'(i)) begin
				sel_pins = pin_in[i] & PORT_MASKS[i*8 +: 8];
				sel_latch = latch_v[i];
				sel_dir = dir_v[i];
			end
		end
	end

	always_comb begin
		cmp_state_nxt = cmp_state_r;
		cmp_res_nxt = cmp_res_r;
		case (cmp_state_r)
			CMP_IDLE: begin
				if (we_cmp) cmp_state_nxt = CMP_END;
			end
			CMP_END: begin
				cmp_state_nxt = CMP_IDLE;
				if (cmp_sel_r == P2_SEL) begin
					cmp_res_nxt = port2_in;
				end else if (cmp_sel_r == 3'(P4_SLOT)) begin
					cmp_res_nxt = ((sel_latch ^ sel_pins) & ~sel_dir) | ((cmp_snap_r ^ sel_pins) & sel_dir);
				end else begin
					cmp_res_nxt = (sel_latch ^ sel_pins) & ~sel_dir;
				end
			end
			default: cmp_state_nxt = CMP_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_state_r <= CMP_IDLE;
			cmp_sel_r <= 3'h0;
			cmp_snap_r <= 8'h00;
			cmp_res_r <= 8'h00;
			cmp_done_r <= 1'b0;
		end else if (ce) begin
			cmp_state_r <= cmp_state_nxt;
			cmp_res_r <= cmp_res_nxt;
			if (we_cmp) begin
				cmp_sel_r <= s_axi_wdata[2:0];
				cmp_done_r <= 1'b0;
			end else if (cmp_state_r == CMP_END) begin
				cmp_done_r <= 1'b1;
			end
			if (cmp_state_r == CMP_IDLE) cmp_snap_r <= sel_pins_at(s_axi_wdata[2:0]);
		end
	end

	property p_reset_inputs;
		@(posedge aclk) !aresetn |=> (pad[0].oe | pad[1].oe | pad[2].oe | pad[3].oe | pad[4].oe | pad[5].oe) == 8'h00;
	endproperty
	a_reset_inputs: assert property (p_reset_inputs) else $error("port pins not inputs after reset");

	property p_read_ctrl_zero;
		@(posedge aclk) disable iff (!aresetn) rvalid_r && rd_addr_r == OFS_READ_CTRL |-> rdata_r[31:1] == 31'h0;
	endproperty
	a_read_ctrl_zero: assert property (p_read_ctrl_zero) else $error("read control upper bits not zero");

	property p_pin_mode_input_zero;
		@(posedge aclk) disable iff (!aresetn)
			rd_go && pin_read_mode_bit && port_hit(s_axi_araddr, 0, OFS_LATCH)
			|=> (rdata_r[7:0] & $past(dir_v[0])) == 8'h00;
	endproperty
	a_pin_mode_input_zero: assert property (p_pin_mode_input_zero) else $error("input pin read nonzero in pin mode");

	property p_pin_mode_output_pin;
		@(posedge aclk) disable iff (!aresetn)
			rd_go && pin_read_mode_bit && port_hit(s_axi_araddr, 0, OFS_LATCH)
			|=> rdata_r[7:0] == ($past(pin_in[0]) & ~$past(dir_v[0]) & PORT_MASKS[7:0]);
	endproperty
	a_pin_mode_output_pin: assert property (p_pin_mode_output_pin) else $error("output pin read not pin level");

	property p_input_match;
		@(posedge aclk) disable iff (!aresetn)
			ce && cmp_state_r == CMP_END && cmp_sel_r != P2_SEL && cmp_sel_r != 3'(P4_SLOT)
			|=> (cmp_res_r & $past(sel_dir)) == 8'h00;
	endproperty
	a_input_match: assert property (p_input_match) else $error("input pin reported mismatch");

	property p_p4_change;
		@(posedge aclk) disable iff (!aresetn)
			ce && cmp_state_r == CMP_END && cmp_sel_r == 3'(P4_SLOT)
			|=> (cmp_res_r & $past(sel_dir)) == (($past(cmp_snap_r) ^ $past(sel_pins)) & $past(sel_dir));
	endproperty
	a_p4_change: assert property (p_p4_change) else $error("port 4 change not reported");

	property p_nmi_no_pullup;
		@(posedge aclk) disable iff (!aresetn) port2_pu[0] == 1'b0;
	endproperty
	a_nmi_no_pullup: assert property (p_nmi_no_pullup) else $error("pull-up on nmi pin");

	property p_pullup_enable;
		@(posedge aclk) disable iff (!aresetn) we_pu_low && wbyte[PU_P0] |=> pad[0].pu == (dir_v[0] & PORT_MASKS[7:0]);
	endproperty
	a_pullup_enable: assert property (p_pullup_enable) else $error("pull-up bit did not enable port");

	property p_pu_high_zero;
		@(posedge aclk) disable iff (!aresetn) (pu_high_r & ~PU_HIGH_IMPL) == 8'h00 && (pu_low_r & ~PU_LOW_IMPL) == 8'h00;
	endproperty
	a_pu_high_zero: assert property (p_pu_high_zero) else $error("unused pull-up bits set");

	property p_pu_inputs_only;
		@(posedge aclk) disable iff (!aresetn) (pad[2].pu & pad[2].oe) == 8'h00 && (pad[5].pu & pad[5].oe) == 8'h00;
	endproperty
	a_pu_inputs_only: assert property (p_pu_inputs_only) else $error("pull-up on driving pin");

	property p_cmp_done;
		@(posedge aclk) disable iff (!aresetn) we_cmp ##1 ce [*2] |-> cmp_done_r;
	endproperty
	a_cmp_done: assert property (p_cmp_done) else $error("compare did not finish in two cycles");
endmodule : gpx_top

// ==== gpx_board_model.sv ====
// Board model that sets the port pin levels from the pads, external drivers and pull-ups.
`timescale 1ns/10ps
module gpx_board_model
	import gpx_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Pads from the port block
	input wire gpx_pad_t [NPORT-1:0] pad,
	// External drivers on the board
	input wire logic [NPORT-1:0][7:0] ext_en,
	input wire logic [NPORT-1:0][7:0] ext_val,
	// Levels seen by the port block
	output logic [NPORT-1:0][7:0] pin_in
);
	logic [7:0] float_r;

	initial float_r = 8'h55;
	// A pin that nobody drives and nothing pulls up changes every cycle.
	always @(posedge aclk) begin
		float_r <= ~float_r;
	end

	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (ext_en[p][b])
					pin_in[p][b] = ext_val[p][b];
				else if (pad[p].oe[b])
					pin_in[p][b] = pad[p].dout[b];
				else if (pad[p].pu[b])
					pin_in[p][b] = 1'b1;
				else
					pin_in[p][b] = float_r[b];
			end
		end
	end
endmodule : gpx_board_model

// ==== tb.sv ====
// Testbench for the port pin access and pull-up block.
`timescale 1ns/10ps
module tb;
	import gpx_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp;
	logic [NPORT-1:0][7:0] pin_in, ctrl_out = '0, ext_en = '0, ext_val = '0;
	logic [7:0] port2_in = 8'hC3, port2_pu;
	gpx_pad_t [NPORT-1:0] pad;
	logic [31:0] rd;
	logic [1:0] rsp;
	int miscompares = 0;
	int check_count = 0;

	always #12.5 aclk = ~aclk;

	gpx_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
		.ctrl_out(ctrl_out), .pad(pad), .port2_in(port2_in), .port2_pu(port2_pu));

	gpx_board_model i_board (.aclk(aclk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask : chk

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, exp_resp});
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		axi_rd(a, rd, rsp);
		chk(rd, exp);
	endtask : rd_chk

	// Starts a compare, polls until done and checks the whole status word.
	task automatic cmp(input logic [2:0] slot, input logic [7:0] exp_res);
		axi_wr(OFS_CMP, {29'h0, slot}, RESP_OKAY);
		for (int n = 0; n < 8; n++) begin
			axi_rd(OFS_CMP, rd, rsp);
			if (rd[CMP_DONE_BIT] === 1'b1) break;
		end
		chk(rd, {14'h0, 2'b01, exp_res, 5'h00, slot});
	endtask : cmp

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (5000) @(posedge aclk);
		miscompares++;
		tally_and_finish;
	end

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (int p = 0; p < NPORT; p++) chk({16'h0, pad[p].oe, pad[p].pu}, 32'h0);
		rd_chk(12'h004, 32'h0000_00FF);
		axi_wr(OFS_READ_CTRL, 32'hFFFF_FFFF, RESP_OKAY);
		rd_chk(OFS_READ_CTRL, 32'h0000_0001);
		axi_wr(OFS_READ_CTRL, 32'h0000_0000, RESP_OKAY);
		axi_wr(OFS_PU_LOW, 32'h0000_00FF, RESP_OKAY);
		rd_chk(OFS_PU_LOW, 32'h0000_003F);
		axi_wr(OFS_PU_HIGH, 32'h0000_00FF, RESP_OKAY);
		// The clock enable held low must stall the read until it returns high.
		fork
			begin
				ce <= 1'b0;
				repeat (2) @(posedge aclk);
				chk({31'h0, arready}, 32'h0);
				ce <= 1'b1;
			end
			rd_chk(OFS_PU_HIGH, 32'h0000_0003);
		join
		chk({24'h0, port2_pu}, 32'h0000_00FE);
		chk({24'h0, pad[0].pu}, 32'h0000_00FF);
		chk({16'h0, pad[4].pu, pad[5].pu}, 32'h0000_3F07);
		// Port slot 3 runs its control function outputs, set once here.
		ctrl_out[3] <= 8'hC6;
		axi_wr(12'h038, 32'h0000_00FF, RESP_OKAY);
		axi_wr(12'h034, 32'h0000_0000, RESP_OKAY);
		chk({8'h0, pad[3].dout, pad[3].oe, pad[3].pu}, 32'h00C6_FF00);
		ext_en[0] <= 8'hFF;
		ext_val[0] <= 8'h3C;
		ext_en[2] <= 8'hFF;
		axi_wr(12'h000, 32'h0000_00A5, RESP_OKAY);
		axi_wr(12'h004, 32'h0000_000F, RESP_OKAY);
		chk({16'h0, pad[0].oe, pad[0].pu}, 32'h0000_F00F);
		rd_chk(12'h000, 32'h0000_00AC);
		// Interrupts are masked in the system before pin read mode is entered.
		axi_wr(OFS_READ_CTRL, 32'h0000_0001, RESP_OKAY);
		rd_chk(12'h000, 32'h0000_0030);
		// A non-maskable handler saves the mode bit on entry and restores it on return.
		rd_chk(OFS_READ_CTRL, 32'h0000_0001);
		axi_wr(OFS_READ_CTRL, 32'h0000_0001, RESP_OKAY);
		axi_wr(OFS_READ_CTRL, 32'h0000_0000, RESP_OKAY);
		rd_chk(12'h000, 32'h0000_00AC);
		cmp(3'h0, 8'h90);
		cmp(3'h2, 8'h00);
		fork
			cmp(3'h2, 8'hFF);
			begin
				repeat (2) @(posedge aclk);
				ext_val[2] <= 8'hFF;
			end
		join
		// Slot 3 control outputs go to input mode before its latch and pins are compared.
		axi_wr(12'h034, 32'h0000_00FF, RESP_OKAY);
		cmp(3'h3, 8'h00);
		cmp(3'h6, 8'hC3);
		axi_rd(12'h100, rd, rsp);
		chk({rd[31:2], rsp}, {30'h0, RESP_SLVERR});
		axi_wr(12'h100, 32'h0000_00FF, RESP_SLVERR);
		tally_and_finish;
	end
endmodule : tb
